// [inc/path_select_defines.svh]
`ifndef PATH_SELECT_DEFINES_SVH
`define PATH_SELECT_DEFINES_SVH
`define ADDR_W 8
`define DATA_W 32
`define PW_W 16
`define CW_W 16
`define STATUS_W 11
`define OFF_PATH_CFG 8'h00
`define OFF_CTRL_WORD 8'h04
`define OFF_SET_PW 8'h08
`define OFF_ENTER_PW 8'h0c
`define OFF_ACCESS 8'h10
`define OFF_STATUS 8'h14
`define CW_CMD_BIT 0
`define CW_REF_BIT 1
`define CW_TK_BIT 11
`define ACC_RUN_BIT 0
`define PW_NONE 16'h0000
`define PW_RESET 16'h0000
`define CW_RESET 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`define ZERO32 32'h0000_0000
`endif

// [inc/path_select_pkg.sv]
package path_select_pkg;
  typedef enum logic [2:0] {
    cfg_keypad_both = 3'b000,
    cfg_terminal_both = 3'b001,
    keypad_cmd_terminal_ref = 3'b010,
    terminal_cmd_keypad_ref = 3'b011,
    switch_by_input = 3'b100,
    switch_by_function_key = 3'b101,
    switch_by_serial_bit = 3'b110
  } path_cfg_e;
  typedef enum logic [1:0] {
    src_keypad = 2'b00,
    src_terminal = 2'b01,
    src_serial = 2'b10
  } src_e;
  typedef enum logic [2:0] {
    status_keypad_both = 3'b000,
    status_terminal_both = 3'b001,
    status_keypad_cmd_terminal_ref = 3'b010,
    status_terminal_cmd_keypad_ref = 3'b011,
    status_serial_partial = 3'b100,
    status_serial_complete = 3'b101
  } status_e;
endpackage

// [design/drive_control_path_select.sv]
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "path_select_defines.svh"
module drive_control_path_select (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic switch_input_pin,
  input wire logic serial_override_input,
  input wire logic function_key_pin,
  input wire logic drive_running,
  input wire logic inactivity_revert,
  input wire logic param_mode_request,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [`DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output path_select_pkg::src_e freq_ref_src_q,
  output path_select_pkg::src_e cmd_src_q,
  output path_select_pkg::status_e path_status_q,
  output logic param_mode_q,
  output logic prompt_q
);
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic sw_s;
  logic ovr_s;
  logic fkey_s;
  logic fkey_prev_q;
  logic fkey_rise;
  logic fkey_sel_q;
  path_select_pkg::path_cfg_e path_cfg_q;
  logic [`CW_W-1:0] ctrl_word_q;
  logic [`PW_W-1:0] set_pw_q;
  logic acc_run_q;
  logic unlocked_q;
  logic aw_full_q;
  logic w_full_q;
  logic [`ADDR_W-1:0] wa_q;
  logic [`DATA_W-1:0] wd_q;
  logic [3:0] ws_q;
  logic sec_en;
  logic cfg_ok;
  logic wr_fire;
  logic pw_confirm;
  logic pw_match;
  logic [1:0] wr_resp;
  logic [`DATA_W-1:0] rd_word;
  logic cmd_ser;
  logic ref_ser;
  logic both_sel;
  path_select_pkg::src_e base_cmd;
  path_select_pkg::src_e base_ref;
  path_select_pkg::src_e next_cmd;
  path_select_pkg::src_e next_ref;
  path_select_pkg::status_e next_status;

  // Decoded register offsets
  function automatic logic reg_known(input logic [`ADDR_W-1:0] a);
    reg_known = (a == `OFF_PATH_CFG) || (a == `OFF_CTRL_WORD) || (a == `OFF_SET_PW) ||
                (a == `OFF_ENTER_PW) || (a == `OFF_ACCESS) || (a == `OFF_STATUS);
  endfunction

  // Offsets guarded by the lock
  function automatic logic reg_guarded(input logic [`ADDR_W-1:0] a);
    reg_guarded = (a == `OFF_PATH_CFG) || (a == `OFF_SET_PW) || (a == `OFF_ACCESS);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end else begin
      pin_meta_q <= {function_key_pin, serial_override_input, switch_input_pin};
      pin_sync_q <= pin_meta_q;
    end
  end
  assign sw_s = pin_sync_q[0];
  assign ovr_s = pin_sync_q[1];
  assign fkey_s = pin_sync_q[2];
  assign fkey_rise = fkey_s && !fkey_prev_q;

  // Function-key toggle of combined source
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fkey_prev_q <= 1'b0;
      fkey_sel_q <= 1'b0;
    end else begin
      fkey_prev_q <= fkey_s;
      if (fkey_rise && path_cfg_q == path_select_pkg::switch_by_function_key) begin
        fkey_sel_q <= !fkey_sel_q;
      end
    end
  end

  // Security and write permission
  assign sec_en = set_pw_q != `PW_NONE;
  assign cfg_ok = !sec_en || (unlocked_q && (acc_run_q || !drive_running));
  assign wr_fire = aw_full_q && w_full_q && !bvalid;
  assign pw_confirm = wr_fire && (wa_q == `OFF_ENTER_PW);
  assign pw_match = wd_q[`PW_W-1:0] == set_pw_q;

  // Write response decision
  always_comb begin
    if (!reg_known(wa_q)) wr_resp = `RESP_DECERR;
    else if (wa_q == `OFF_STATUS) wr_resp = `RESP_SLVERR;
    else if (reg_guarded(wa_q) && !cfg_ok) wr_resp = `RESP_SLVERR;
    else wr_resp = `RESP_OKAY;
  end

  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      path_cfg_q <= path_select_pkg::cfg_keypad_both;
      set_pw_q <= `PW_RESET;
      acc_run_q <= 1'b0;
    end else if (wr_fire && wr_resp == `RESP_OKAY) begin
      if (wa_q == `OFF_PATH_CFG && ws_q[0]) path_cfg_q <= path_select_pkg::path_cfg_e'(wd_q[2:0]);
      if (wa_q == `OFF_SET_PW) set_pw_q <= merge16(set_pw_q, wd_q, ws_q);
      if (wa_q == `OFF_ACCESS && ws_q[0]) acc_run_q <= wd_q[`ACC_RUN_BIT];
    end
  end

  // Serial control word, writable at any time
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_word_q <= `CW_RESET;
    end else if (wr_fire && wa_q == `OFF_CTRL_WORD) begin
      ctrl_word_q <= merge16(ctrl_word_q, wd_q, ws_q);
    end
  end

  // Unlock state; a match wins over a revert
  always_ff @(posedge core_clk) begin
    if (reset) begin
      unlocked_q <= 1'b0;
    end else if (pw_confirm && pw_match) begin
      unlocked_q <= 1'b1;
    end else if (pw_confirm || inactivity_revert) begin
      unlocked_q <= 1'b0;
    end
  end

  // Parameter mode entry with password prompt
  always_ff @(posedge core_clk) begin
    if (reset) begin
      param_mode_q <= 1'b0;
      prompt_q <= 1'b0;
    end else if (param_mode_request && !param_mode_q) begin
      if (!sec_en || unlocked_q) param_mode_q <= 1'b1;
      else prompt_q <= 1'b1;
    end else if (prompt_q && pw_confirm) begin
      prompt_q <= 1'b0;
      param_mode_q <= pw_match;
    end else if (inactivity_revert) begin
      param_mode_q <= 1'b0;
      prompt_q <= 1'b0;
    end
  end

  // Source selection from setting, serial bits and override
  always_comb begin
    both_sel = 1'b0;
    base_cmd = path_select_pkg::src_keypad;
    base_ref = path_select_pkg::src_keypad;
    unique case (path_cfg_q)
      path_select_pkg::cfg_keypad_both: both_sel = 1'b0;
      path_select_pkg::cfg_terminal_both: both_sel = 1'b1;
      path_select_pkg::keypad_cmd_terminal_ref: base_ref = path_select_pkg::src_terminal;
      path_select_pkg::terminal_cmd_keypad_ref: base_cmd = path_select_pkg::src_terminal;
      path_select_pkg::switch_by_input: both_sel = sw_s;
      path_select_pkg::switch_by_function_key: both_sel = fkey_sel_q;
      path_select_pkg::switch_by_serial_bit: both_sel = ctrl_word_q[`CW_TK_BIT];
      default: both_sel = 1'b0;
    endcase
    if (both_sel) begin
      base_cmd = path_select_pkg::src_terminal;
      base_ref = path_select_pkg::src_terminal;
    end
    cmd_ser = ctrl_word_q[`CW_CMD_BIT] && !ovr_s;
    ref_ser = ctrl_word_q[`CW_REF_BIT] && !ovr_s;
    next_cmd = cmd_ser ? path_select_pkg::src_serial : base_cmd;
    next_ref = ref_ser ? path_select_pkg::src_serial : base_ref;
    if (cmd_ser && ref_ser) next_status = path_select_pkg::status_serial_complete;
    else if (cmd_ser || ref_ser) next_status = path_select_pkg::status_serial_partial;
    else if (base_cmd == base_ref && base_cmd == path_select_pkg::src_keypad)
      next_status = path_select_pkg::status_keypad_both;
    else if (base_cmd == base_ref) next_status = path_select_pkg::status_terminal_both;
    else if (base_cmd == path_select_pkg::src_keypad)
      next_status = path_select_pkg::status_keypad_cmd_terminal_ref;
    else next_status = path_select_pkg::status_terminal_cmd_keypad_ref;
  end

  // Registered active-source indicators
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_src_q <= path_select_pkg::src_keypad;
      freq_ref_src_q <= path_select_pkg::src_keypad;
      path_status_q <= path_select_pkg::status_keypad_both;
    end else begin
      cmd_src_q <= next_cmd;
      freq_ref_src_q <= next_ref;
      path_status_q <= next_status;
    end
  end

  // Write address channel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      awready <= 1'b0;
      aw_full_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      awready <= awvalid && !aw_full_q && !awready;
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        wa_q <= awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wready <= 1'b0;
      w_full_q <= 1'b0;
      wd_q <= `ZERO32;
      ws_q <= 4'h0;
    end else begin
      wready <= wvalid && !w_full_q && !wready;
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response channel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_resp;
    end else if (bready && bvalid) begin
      bvalid <= 1'b0;
    end
  end

  // Read data selection; passwords read as zero
  always_comb begin
    rd_word = `ZERO32;
    unique case (araddr)
      `OFF_PATH_CFG: rd_word[2:0] = path_cfg_q;
      `OFF_CTRL_WORD: rd_word[`CW_W-1:0] = ctrl_word_q;
      `OFF_ACCESS: rd_word[`ACC_RUN_BIT] = acc_run_q;
      `OFF_STATUS: rd_word[`STATUS_W-1:0] = {unlocked_q, sec_en, prompt_q, param_mode_q,
                                            path_status_q, cmd_src_q, freq_ref_src_q};
      default: rd_word = `ZERO32;
    endcase
  end

  // Read channel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= `ZERO32;
      rresp <= `RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= reg_known(araddr) ? `RESP_OKAY : `RESP_DECERR;
      end else if (rready && rvalid) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_lock;
    wr_fire && sec_en && !unlocked_q && wa_q == `OFF_PATH_CFG
      |=> bresp == `RESP_SLVERR && path_cfg_q == $past(path_cfg_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write accepted");
  property p_match;
    pw_confirm && sec_en && pw_match
      |=> unlocked_q ##1 (unlocked_q || $past(inactivity_revert));
  endproperty
  a_match: assert property (p_match) else $error("match did not unlock");
  property p_mismatch;
    pw_confirm && !pw_match && unlocked_q |=> !unlocked_q;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch kept unlock");
  property p_relock;
    inactivity_revert && !pw_confirm && !param_mode_request |=> !unlocked_q && !param_mode_q;
  endproperty
  a_relock: assert property (p_relock) else $error("revert did not relock");
  property p_prompt;
    param_mode_request && !param_mode_q && sec_en && !unlocked_q
      |=> prompt_q && !param_mode_q;
  endproperty
  a_prompt: assert property (p_prompt) else $error("mode entered without password");
  property p_nosec;
    wr_fire && !sec_en && wa_q == `OFF_ACCESS |=> bresp == `RESP_OKAY && bvalid;
  endproperty
  a_nosec: assert property (p_nosec) else $error("write refused with security off");
  property p_running;
    wr_fire && sec_en && unlocked_q && !acc_run_q && drive_running && wa_q == `OFF_PATH_CFG
      |=> bresp == `RESP_SLVERR;
  endproperty
  a_running: assert property (p_running) else $error("basic write while running");
  property p_override;
    ovr_s |=> cmd_src_q != path_select_pkg::src_serial &&
              freq_ref_src_q != path_select_pkg::src_serial;
  endproperty
  a_override: assert property (p_override) else $error("override ignored");
  property p_ser_cmd;
    ctrl_word_q[`CW_CMD_BIT] && !ovr_s |=> cmd_src_q == path_select_pkg::src_serial;
  endproperty
  a_ser_cmd: assert property (p_ser_cmd) else $error("serial command path missing");
  property p_ser_ref;
    ctrl_word_q[`CW_REF_BIT] && !ovr_s |=> freq_ref_src_q == path_select_pkg::src_serial;
  endproperty
  a_ser_ref: assert property (p_ser_ref) else $error("serial reference missing");
  property p_status;
    !ovr_s && (ctrl_word_q[`CW_CMD_BIT] ^ ctrl_word_q[`CW_REF_BIT])
      |=> path_status_q == path_select_pkg::status_serial_partial;
  endproperty
  a_status: assert property (p_status) else $error("partial status wrong");
  property p_together;
    path_cfg_q[2] && !cmd_ser && !ref_ser |=> cmd_src_q == freq_ref_src_q;
  endproperty
  a_together: assert property (p_together) else $error("mixed switched path");
  property p_input;
    path_cfg_q == path_select_pkg::switch_by_input && !cmd_ser && !ref_ser && !sw_s
      |=> cmd_src_q == path_select_pkg::src_keypad;
  endproperty
  a_input: assert property (p_input) else $error("input false not keypad");
  property p_fkey;
    fkey_rise && path_cfg_q == path_select_pkg::switch_by_function_key
      |=> fkey_sel_q != $past(fkey_sel_q);
  endproperty
  a_fkey: assert property (p_fkey) else $error("function key did not toggle");
  property p_serbit;
    path_cfg_q == path_select_pkg::switch_by_serial_bit && ctrl_word_q[`CW_TK_BIT] && !cmd_ser
      |=> cmd_src_q == path_select_pkg::src_terminal;
  endproperty
  a_serbit: assert property (p_serbit) else $error("serial bit not terminal");
  property p_reset_clear;
    @(posedge core_clk) disable iff (1'b0)
      reset |=> ctrl_word_q == `CW_RESET && !unlocked_q && pin_sync_q == 3'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
  c_unlock: cover property (pw_confirm && pw_match && sec_en);
  c_complete: cover property (path_status_q == path_select_pkg::status_serial_complete);
  c_refused: cover property (bvalid && bresp == `RESP_SLVERR);
  c_toggle: cover property (fkey_rise && path_cfg_q == path_select_pkg::switch_by_function_key);
endmodule

// [verification/drive_partner.sv]
`timescale 1ns/1ps
// Keypad, terminal strip and serial master as seen from the drive
module drive_partner (
  input wire logic core_clk,
  output logic switch_input_pin,
  output logic serial_override_input,
  output logic function_key_pin,
  output logic drive_running,
  output logic inactivity_revert,
  output logic param_mode_request,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Everything idle at time zero
  initial begin
    {switch_input_pin, serial_override_input, function_key_pin, drive_running} = 4'h0;
    {inactivity_revert, param_mode_request, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
  end
  // Terminal strip levels and run state
  task automatic pins(input logic sw, input logic ov, input logic run);
    @(posedge core_clk);
    switch_input_pin <= sw;
    serial_override_input <= ov;
    drive_running <= run;
  endtask
  // Key held long enough to pass the input synchroniser
  task automatic key_press();
    @(posedge core_clk);
    function_key_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    function_key_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // One-cycle keypad pulse: revert or mode request
  task automatic pulse(input logic rev);
    @(posedge core_clk);
    inactivity_revert <= rev;
    param_mode_request <= ~rev;
    @(posedge core_clk);
    inactivity_revert <= 1'b0;
    param_mode_request <= 1'b0;
  endtask
  // Serial master writes, control word included, each channel dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  // Read with rready held until the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

// [verification/drive_control_path_select_tb.sv]
`timescale 1ns/1ps
`include "path_select_defines.svh"
module drive_control_path_select_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic switch_input_pin, serial_override_input, function_key_pin, drive_running;
  logic inactivity_revert, param_mode_request, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready, param_mode_q, prompt_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  path_select_pkg::src_e freq_ref_src_q, cmd_src_q;
  path_select_pkg::status_e path_status_q;
  logic [6:0] path_now;
  logic fk_q = 1'b0;
  int fail_count = 0;
  int compares = 0;
  // Clock and combined source view
  always #20 core_clk = ~core_clk;
  assign path_now = {path_status_q, cmd_src_q, freq_ref_src_q};
  drive_control_path_select i_drive_control_path_select (
    .core_clk(core_clk), .reset(reset), .switch_input_pin(switch_input_pin),
    .serial_override_input(serial_override_input), .function_key_pin(function_key_pin),
    .drive_running(drive_running), .inactivity_revert(inactivity_revert),
    .param_mode_request(param_mode_request), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .freq_ref_src_q(freq_ref_src_q), .cmd_src_q(cmd_src_q), .path_status_q(path_status_q),
    .param_mode_q(param_mode_q), .prompt_q(prompt_q));
  drive_partner i_drive_partner (
    .core_clk(core_clk), .switch_input_pin(switch_input_pin),
    .serial_override_input(serial_override_input), .function_key_pin(function_key_pin),
    .drive_running(drive_running), .inactivity_revert(inactivity_revert),
    .param_mode_request(param_mode_request), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // Value and response comparisons
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: resp got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    i_drive_partner.wr(a, d, r);
    chk_resp(r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_drive_partner.rd(a, d, r);
    chk_resp(r, er);
    chk(d, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Expected {status, cmd, ref} from setting, control word and pins
  function automatic logic [6:0] exp_path(input logic [2:0] cfg, input logic [15:0] cw,
                                          input logic sw, input logic ov, input logic fk);
    logic [1:0] c, r;
    logic [2:0] st;
    logic t;
    t = (cfg == 3'h4) ? sw : ((cfg == 3'h5) ? fk : cw[11]);
    case (cfg)
      3'h1: {c, r} = 4'h5;
      3'h2: {c, r} = 4'h1;
      3'h3: {c, r} = 4'h4;
      3'h4, 3'h5, 3'h6: {c, r} = {1'b0, t, 1'b0, t};
      default: {c, r} = 4'h0;
    endcase
    st = (c == r) ? {2'h0, c[0]} : {2'h1, c[0]};
    if (!ov && (cw[1:0] != 2'h0)) begin
      if (cw[0]) c = 2'h2;
      if (cw[1]) r = 2'h2;
      st = (cw[1:0] == 2'h3) ? 3'h5 : 3'h4;
    end
    return {st, c, r};
  endfunction
  // Every path code, then random mixes of pins and control bits
  task automatic path_test();
    logic [2:0] cfg;
    logic [15:0] cw;
    logic sw, ov;
    logic [6:0] e;
    for (int i = 0; i < 40; i++) begin
      cfg = (i < 8) ? i[2:0] : 3'($urandom);
      cw = 16'($urandom);
      cw = (i < 8) ? (cw & 16'hfffc) : cw;
      sw = 1'($urandom);
      ov = (i < 16) ? 1'b0 : 1'($urandom);
      i_drive_partner.pins(sw, ov, 1'b0);
      wchk(`OFF_PATH_CFG, {29'h0, cfg}, `RESP_OKAY);
      if (cfg == 3'h5) begin
        i_drive_partner.key_press();
        fk_q = ~fk_q;
      end
      wchk(`OFF_CTRL_WORD, {16'h0, cw}, `RESP_OKAY);
      wt(6);
      e = exp_path(cfg, cw, sw, ov, fk_q);
      chk(path_now, e);
      rchk(`OFF_STATUS, {25'h0, e}, `RESP_OKAY);
    end
    $display("test path done");
  endtask
  // Password lock, access levels and keypad prompt
  task automatic sec_test();
    i_drive_partner.pins(1'b0, 1'b0, 1'b0);
    wchk(`OFF_CTRL_WORD, 32'h0, `RESP_OKAY);
    wchk(`OFF_PATH_CFG, 32'h1, `RESP_OKAY);
    wchk(`OFF_SET_PW, 32'h1234, `RESP_OKAY);
    rchk(`OFF_SET_PW, 32'h0, `RESP_OKAY);
    wchk(`OFF_PATH_CFG, 32'h0, `RESP_SLVERR);
    i_drive_partner.pulse(1'b0);
    wt(1);
    chk({param_mode_q, prompt_q}, 32'h1);
    wchk(`OFF_ENTER_PW, 32'h4321, `RESP_OKAY);
    wt(2);
    chk({param_mode_q, prompt_q}, 32'h0);
    wchk(`OFF_PATH_CFG, 32'h0, `RESP_SLVERR);
    i_drive_partner.pulse(1'b0);
    wchk(`OFF_ENTER_PW, 32'h1234, `RESP_OKAY);
    wt(2);
    chk({param_mode_q, prompt_q}, 32'h2);
    i_drive_partner.pins(1'b0, 1'b0, 1'b1);
    wchk(`OFF_PATH_CFG, 32'h0, `RESP_SLVERR);
    i_drive_partner.pins(1'b0, 1'b0, 1'b0);
    wchk(`OFF_PATH_CFG, 32'h2, `RESP_OKAY);
    wchk(`OFF_ACCESS, 32'h1, `RESP_OKAY);
    i_drive_partner.pins(1'b0, 1'b0, 1'b1);
    wchk(`OFF_PATH_CFG, 32'h3, `RESP_OKAY);
    i_drive_partner.pulse(1'b1);
    wt(1);
    chk({param_mode_q, prompt_q}, 32'h0);
    wchk(`OFF_PATH_CFG, 32'h0, `RESP_SLVERR);
    wchk(`OFF_ENTER_PW, 32'h1234, `RESP_OKAY);
    wchk(`OFF_SET_PW, 32'h0, `RESP_OKAY);
    i_drive_partner.pulse(1'b1);
    wchk(`OFF_PATH_CFG, 32'h0, `RESP_OKAY);
    rchk(`OFF_PATH_CFG, 32'h0, `RESP_OKAY);
    rchk(`OFF_ACCESS, 32'h1, `RESP_OKAY);
    $display("test security done");
  endtask
  // Reset state, map refusals and a second reset
  task automatic reg_test(input logic again);
    if (again) begin
      wchk(`OFF_CTRL_WORD, 32'h3, `RESP_OKAY);
      @(posedge core_clk);
      reset <= 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
    end
    wt(1);
    chk(path_now, 32'h0);
    rchk(`OFF_CTRL_WORD, 32'h0, `RESP_OKAY);
    rchk(`OFF_STATUS, 32'h0, `RESP_OKAY);
    rchk(8'h20, 32'h0, `RESP_DECERR);
    wchk(8'h20, 32'hffff_ffff, `RESP_DECERR);
    wchk(`OFF_STATUS, 32'h7ff, `RESP_SLVERR);
    $display("test registers done");
  endtask
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'hc9d7_bd0d));
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    reg_test(1'b0);
    path_test();
    sec_test();
    reg_test(1'b1);
    test_done();
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    test_done();
  end
endmodule
